// ---- hdl/pfpp_pkg.sv ----
// constants for the flash programming port controller (programmer side)
// assumes a 20 MHz system clock and the device pins reached through pads that resolve the enables
package pfpp_pkg;
  localparam int DATA_W = 16;
  localparam int MODE_W = 4;
  localparam int REQ_W = DATA_W + MODE_W + 1;
  localparam int REQ_DATA_LSB = 0;
  localparam int REQ_MODE_LSB = DATA_W;
  localparam int REQ_READ_BIT = DATA_W + MODE_W;
  localparam int FIFO_DEPTH = 8;
  // mode codes that select the latched word's destination
  localparam logic [MODE_W-1:0] MODE_COMMAND = 4'h0;
  localparam logic [MODE_W-1:0] MODE_ADDR_FIRST = 4'h1;
  localparam logic [MODE_W-1:0] MODE_ADDR_SECOND = 4'h2;
  localparam logic [MODE_W-1:0] MODE_ADDR_THIRD = 4'h3;
  localparam logic [MODE_W-1:0] MODE_ADDR_LAST = 4'h4;
  localparam logic [MODE_W-1:0] MODE_DATA = 4'h5;
  // command words
  localparam logic [DATA_W-1:0] CMD_READ = 16'h0011;
  localparam logic [DATA_W-1:0] CMD_PAGE_WRITE = 16'h0012;
  localparam logic [DATA_W-1:0] CMD_WRITE_LOCK = 16'h0022;
  localparam logic [DATA_W-1:0] CMD_ERASE_WRITE = 16'h0032;
  localparam logic [DATA_W-1:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
  localparam logic [DATA_W-1:0] CMD_ERASE_ALL = 16'h0013;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_REGIONS = 16'h0024;
  localparam logic [DATA_W-1:0] ERASE_ALL_ARG = 16'h0000;
  // timing
  localparam int CLK_KHZ = 20000;
  localparam int SETUP_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [7:0] {
    PFPP_IDLE = 8'h01,
    PFPP_SETUP = 8'h02,
    PFPP_WAIT_BUSY = 8'h04,
    PFPP_RELEASE = 8'h08,
    PFPP_WAIT_VALID = 8'h10,
    PFPP_WAIT_INPUT = 8'h20,
    PFPP_RESUME = 8'h40,
    PFPP_WAIT_READY = 8'h80
  } pfpp_state_e;
endpackage

// ---- hdl/pfpp_programmer.sv ----
// programmer-side flash programming port controller and its request fifo
// assumes: device pins reach it through pads that resolve the enables;
// ready, data-valid and data inputs are asynchronous to clk_sys
`timescale 1ns/1ns

// ********************************************************************
// request fifo
// ********************************************************************
module pfpp_fifo
  import pfpp_pkg::*;
#(
  parameter int WIDTH = REQ_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_BITS = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ZERO = '0;
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(DEPTH);
  localparam logic [CNT_BITS-1:0] CNT_ONE_F = CNT_BITS'(1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_BITS-1:0] count;
  logic [CNT_BITS-1:0] next_count;
  logic push;
  logic pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];
  always_comb
  begin
    next_count = count;
    if (push & ~pop)
      next_count = count + CNT_ONE_F;
    else if (pop & ~push)
      next_count = count - CNT_ONE_F;
  end
  // flags held in flops so the ready seen by the source is clean
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      count <= next_count;
      in_ready <= (next_count != CNT_FULL);
      out_valid <= (next_count != '0);
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= PTR_ZERO;
      rd_ptr <= PTR_ZERO;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? PTR_ZERO : wr_ptr + PTR_ONE;
      if (pop)
        rd_ptr <= (rd_ptr == PTR_LAST) ? PTR_ZERO : rd_ptr + PTR_ONE;
    end
  end
  // storage needs no reset; out_valid guards stale words
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule // pfpp_fifo

// ********************************************************************
// handshake sequencer
// ********************************************************************
module pfpp_programmer
  import pfpp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [MODE_W-1:0] req_mode,
  input wire logic [DATA_W-1:0] req_data,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic done,
  output logic busy,
  output logic prog_command_strobe_pin,
  output logic prog_output_enable_pin,
  input wire logic prog_ready_pin,
  input wire logic prog_data_valid_pin,
  output logic [MODE_W-1:0] prog_mode_pins,
  output logic prog_mode_oe,
  input wire logic [DATA_W-1:0] prog_data_pins_in,
  output logic [DATA_W-1:0] prog_data_pins_out,
  output logic prog_data_pins_oe
);
  pfpp_state_e state;
  logic [REQ_W-1:0] head;
  logic head_valid;
  logic take;
  logic is_read;
  logic [CNT_W-1:0] cnt;
  logic ready_meta;
  logic ready_sync;
  logic valid_n_meta;
  logic valid_n_sync;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  // ******************************************************************
  // input synchronisers
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
      valid_n_meta <= 1'b1;
      valid_n_sync <= 1'b1;
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      ready_meta <= prog_ready_pin;
      ready_sync <= ready_meta;
      valid_n_meta <= prog_data_valid_pin;
      valid_n_sync <= valid_n_meta;
      data_meta <= prog_data_pins_in;
      data_sync <= data_meta;
    end
  end
  // the sequencer drains one request per handshake, so a slow device
  // fills the fifo and req_ready drops; strict order keeps the caller's
  // command, address and data sequence intact on the pins
  pfpp_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_read, req_mode, req_data}),
    .out_valid(head_valid),
    .out_ready(take),
    .out_data(head)
  );
  // a new handshake starts only from idle with ready seen high
  assign take = (state == PFPP_IDLE) & head_valid & ready_sync;
  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= PFPP_IDLE;
      cnt <= CNT_ZERO;
      is_read <= 1'b0;
    end
    else
    begin
      unique case (state)
        PFPP_IDLE:
        begin
          if (take)
          begin
            is_read <= head[REQ_READ_BIT];
            cnt <= SETUP_CNT;
            state <= PFPP_SETUP;
          end
        end
        PFPP_SETUP:
        begin
          // mode and data settle before the strobe falls
          if (cnt <= CNT_ONE)
            state <= PFPP_WAIT_BUSY;
          else
            cnt <= cnt - CNT_ONE;
        end
        PFPP_WAIT_BUSY:
          if (~ready_sync)
            state <= PFPP_RELEASE;
        PFPP_RELEASE:
        begin
          if (is_read)
            state <= PFPP_WAIT_VALID;
          else
            state <= PFPP_WAIT_READY;
        end
        PFPP_WAIT_VALID:
          if (~valid_n_sync)
            state <= PFPP_WAIT_INPUT;
        PFPP_WAIT_INPUT:
          if (valid_n_sync)
            state <= PFPP_RESUME;
        PFPP_RESUME:
          state <= PFPP_WAIT_READY;
        PFPP_WAIT_READY:
        begin
          // strobe is already high here, so ready high ends the handshake
          if (ready_sync)
            state <= PFPP_IDLE;
        end
        default:
          state <= PFPP_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // pin drivers
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prog_command_strobe_pin <= 1'b1;
      prog_output_enable_pin <= 1'b1;
      prog_mode_pins <= MODE_COMMAND;
      prog_mode_oe <= 1'b0;
      prog_data_pins_out <= '0;
      prog_data_pins_oe <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        // mode codes and command words come from the caller as-is
        prog_mode_pins <= head[REQ_MODE_LSB +: MODE_W];
        prog_data_pins_out <= head[REQ_DATA_LSB +: DATA_W];
        prog_mode_oe <= 1'b1;
        prog_data_pins_oe <= 1'b1;
      end
      if ((state == PFPP_SETUP) && (cnt <= CNT_ONE))
        prog_command_strobe_pin <= 1'b0;
      if ((state == PFPP_WAIT_BUSY) && ~ready_sync)
      begin
        prog_mode_oe <= 1'b0;
        prog_data_pins_oe <= 1'b0;
      end
      if (state == PFPP_RELEASE)
      begin
        if (is_read)
          prog_output_enable_pin <= 1'b0;
        else
          prog_command_strobe_pin <= 1'b1;
      end
      if ((state == PFPP_WAIT_VALID) && ~valid_n_sync)
        prog_output_enable_pin <= 1'b1;
      if ((state == PFPP_WAIT_INPUT) && valid_n_sync)
        prog_data_pins_oe <= 1'b1;
      if (state == PFPP_RESUME)
        prog_command_strobe_pin <= 1'b1;
      if ((state == PFPP_WAIT_READY) && ready_sync)
        prog_data_pins_oe <= 1'b0;
    end
  end

  // ******************************************************************
  // user-side answers
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      done <= 1'b0;
      // data was driven before data-valid fell and passed the same
      // two-stage delay, so it is stable when the flag is seen
      if ((state == PFPP_WAIT_VALID) && ~valid_n_sync)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= data_sync;
      end
      if ((state == PFPP_WAIT_READY) && ready_sync)
        done <= 1'b1;
      busy <= (state != PFPP_IDLE) | head_valid;
    end
  end
endmodule // pfpp_programmer

// ---- testbench/pfpp_checker_sva.sv ----
// pin-level checks on the programmer handshake
// assumes bind into pfpp_programmer, pins sampled on clk_sys
`timescale 1ns/1ns
// ************
// pin checker
// ************
module pfpp_checker
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic done,
  input wire logic prog_command_strobe_pin,
  input wire logic prog_output_enable_pin,
  input wire logic prog_ready_pin,
  input wire logic prog_data_valid_pin,
  input wire logic prog_mode_oe,
  input wire logic prog_data_pins_oe
);
  wire s = prog_command_strobe_pin;
  wire oe = prog_output_enable_pin;
  wire rdy = prog_ready_pin;
  wire dv = prog_data_valid_pin;
  wire moe = prog_mode_oe;
  wire doe = prog_data_pins_oe;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_on_ready: assert property (
    $fell(s) |-> $past(rdy)) else $error("strobe fell, ready low");
  a_setup_then_strobe: assert property (
    $rose(moe) |-> s[*2] ##[1:2] !s && moe && doe) else $error("setup");
  a_release_mode: assert property (
    $rose(s) |-> !moe && !$past(moe) && !$past(rdy)) else $error("release");
  a_float_before_oe: assert property (
    $fell(oe) |-> !doe && !$past(doe)) else $error("bus driven at oe");
  a_sample_on_valid: assert property (
    rsp_valid |-> !$past(dv, 2) && oe) else $error("early sample");
  a_oe_inside_cmd: assert property (
    !oe |-> !s) else $error("oe low outside strobe");
  a_resume_drive: assert property (
    $rose(doe) && !moe |-> $past(dv) && oe && !s) else $error("resume");
  a_done_ready: assert property (
    done |-> s && $past(rdy, 2) && !moe && !doe) else $error("done early");
  c_read: cover property (rsp_valid);
  c_done: cover property (done);
  c_full: cover property (!req_ready);
endmodule // pfpp_checker
bind pfpp_programmer pfpp_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .done(done),
  .prog_command_strobe_pin(prog_command_strobe_pin),
  .prog_output_enable_pin(prog_output_enable_pin),
  .prog_ready_pin(prog_ready_pin), .prog_data_valid_pin(prog_data_valid_pin),
  .prog_mode_oe(prog_mode_oe), .prog_data_pins_oe(prog_data_pins_oe));

// ---- testbench/pfpp_flash_model.sv ----
// behavioural flash device answering the programming handshake
// assumes the bench resolves the shared wires with pull-ups
`timescale 1ns/1ns
// ************
// device model
// ************
module pfpp_flash_model
  import pfpp_pkg::*;
(
  input wire logic command_strobe_n,
  input wire logic output_enable_n,
  input wire logic slow,
  input wire logic [MODE_W-1:0] mode,
  input wire logic [DATA_W-1:0] bus_in,
  output logic ready,
  output logic data_valid_n,
  output logic [DATA_W-1:0] bus_out,
  output logic bus_oe
);
  // 64 words, pages of 4 words, lock regions of 16 words
  logic [DATA_W-1:0] mem [0:63];
  logic [DATA_W-1:0] lbuf [0:63];
  logic [63:0] lvalid;
  logic [3:0] locked, lpg;
  logic [DATA_W-1:0] cmd, wd;
  logic [MODE_W-1:0] md;
  logic [31:0] addr;
  int dly;
  task automatic commit();
    for (int i = 0; i < 64; i++)
      if (lvalid[i] && cmd inside {CMD_ERASE_WRITE, CMD_ERASE_WRITE_LOCK})
        for (int j = 0; j < 4; j++) mem[i / 4 * 4 + j] = 16'hffff;
    for (int i = 0; i < 64; i++)
      if (lvalid[i])
      begin
        mem[i] = lbuf[i];
        if (cmd inside {CMD_WRITE_LOCK, CMD_ERASE_WRITE_LOCK})
          locked[i / 16] = 1'b1;
      end
    lvalid = '0;
  endtask
  initial
  begin
    ready = 1'b1;
    data_valid_n = 1'b1;
    bus_oe = 1'b0;
    bus_out = '0;
    lvalid = '0;
    locked = '0;
    cmd = '0;
    addr = '0;
    lpg = '0;
    for (int i = 0; i < 64; i++) mem[i] = 16'ha500 + 16'(i);
    forever
    begin
      @(negedge command_strobe_n);
      md = mode;
      wd = bus_in;
      // response lag stands in for the device's own input synchronisers
      dly = slow ? 400 : 30;
      #(dly) ready = 1'b0;
      if (md == MODE_COMMAND)
      begin
        commit();
        cmd = wd;
        if (cmd == CMD_UNLOCK_REGIONS) locked = '0;
      end
      else if (md inside {[MODE_ADDR_FIRST:MODE_ADDR_LAST]})
        addr[(md - 1) * 8 +: 8] = wd[7:0];
      else if (md == MODE_DATA && cmd == CMD_READ)
      begin
        @(negedge output_enable_n);
        #(dly) bus_oe = 1'b1;
        bus_out = mem[addr[6:1]];
        #(dly) data_valid_n = 1'b0;
        @(posedge output_enable_n);
        bus_oe = 1'b0;
        #(dly) data_valid_n = 1'b1;
        addr = addr + 2;
      end
      else if (md == MODE_DATA && cmd == CMD_ERASE_ALL)
      begin
        // a locked region cancels the whole erase
        if (wd == ERASE_ALL_ARG && locked == '0)
          for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
      end
      else if (md == MODE_DATA)
      begin
        if (lvalid != '0 && addr[6:3] != lpg) commit();
        lpg = addr[6:3];
        lbuf[addr[6:1]] = wd;
        lvalid[addr[6:1]] = 1'b1;
        addr = addr + 2;
      end
      wait (command_strobe_n);
      #(dly) ready = 1'b1;
    end
  end
endmodule // pfpp_flash_model

// ---- testbench/tb_top.sv ----
// self-checking bench: programmer controller against the device model
// assumes pull-ups on the shared mode and data wires
`timescale 1ns/1ns
// ************
// bench
// ************
module tb_top
  import pfpp_pkg::*;
;
  localparam int LIMIT = 20000;
  logic clk_sys, rst, req_valid, req_read, slow, saw_full;
  logic [MODE_W-1:0] req_mode, mpins;
  logic [DATA_W-1:0] req_data, rsp_data, dout, dev_out;
  logic req_ready, rsp_valid, done, busy, cs_n, oe_n, rdy, dv_n, moe, doe, d_oe;
  wire [MODE_W-1:0] mode_w = moe ? mpins : 4'hf;
  wire [DATA_W-1:0] bus = doe ? (d_oe ? 16'hxxxx : dout) :
    (d_oe ? dev_out : 16'hffff);
  int miscompares, compares, pushed, done_cnt, cycles;
  logic [DATA_W-1:0] rdq [$];
  pfpp_programmer DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_mode(req_mode),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .done(done), .busy(busy), .prog_command_strobe_pin(cs_n),
    .prog_output_enable_pin(oe_n), .prog_ready_pin(rdy),
    .prog_data_valid_pin(dv_n), .prog_mode_pins(mpins), .prog_mode_oe(moe),
    .prog_data_pins_in(bus), .prog_data_pins_out(dout),
    .prog_data_pins_oe(doe));
  pfpp_flash_model dev (.command_strobe_n(cs_n), .output_enable_n(oe_n),
    .slow(slow), .mode(mode_w), .bus_in(bus), .ready(rdy),
    .data_valid_n(dv_n), .bus_out(dev_out), .bus_oe(d_oe));
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] e,
    input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h saw %h", what, e, g);
    end
  endtask
  task automatic got(input logic [DATA_W-1:0] e);
    chk("read word", e, rdq.size() > 0 ? rdq.pop_front() : 16'hxxxx);
  endtask
  // request held until the edge that sees req_ready high
  task automatic p(input logic r, input logic [MODE_W-1:0] m,
    input logic [DATA_W-1:0] d);
    req_valid = 1'b1;
    req_read = r;
    req_mode = m;
    req_data = d;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    pushed++;
  endtask
  task automatic seek(input logic [31:0] a);
    for (int i = 0; i < 4; i++) p(1'b0, MODE_W'(i + 1), {8'h00, a[i*8 +: 8]});
  endtask
  task automatic settle();
    req_valid = 1'b0;
    for (int i = 0; i < 4000 && done_cnt != pushed; i++) @(posedge clk_sys) #1;
    chk("handshakes done", 16'(pushed), 16'(done_cnt));
    chk("busy when drained", 16'h0000, {15'h0000, busy});
  endtask
  task automatic t_fifo_full();
    slow = 1'b1;
    p(1'b0, MODE_COMMAND, CMD_READ);
    seek(32'h0000_0000);
    p(1'b0, 4'h7, 16'h0000);
    for (int i = 0; i < 6; i++) p(1'b1, MODE_DATA, 16'h0000);
    settle();
    slow = 1'b0;
    chk("queue full seen", 16'h0001, {15'h0000, saw_full});
    for (int i = 0; i < 6; i++) got(16'ha500 + 16'(i));
  endtask
  task automatic t_page_write();
    p(1'b0, MODE_COMMAND, CMD_PAGE_WRITE);
    seek(32'h0000_0006);
    p(1'b0, MODE_DATA, 16'h1111);
    p(1'b0, MODE_DATA, 16'h2222);
    p(1'b0, MODE_COMMAND, CMD_READ);
    seek(32'h0000_0006);
    repeat (3) p(1'b1, MODE_DATA, 16'h0000);
    seek(32'h0000_0002);
    p(1'b1, MODE_DATA, 16'h0000);
    settle();
    got(16'h1111);
    got(16'h2222);
    got(16'ha505);
    got(16'ha501);
  endtask
  task automatic t_erase_write();
    p(1'b0, MODE_COMMAND, CMD_ERASE_WRITE);
    seek(32'h0000_0010);
    p(1'b0, MODE_DATA, 16'h3333);
    p(1'b0, MODE_COMMAND, CMD_READ);
    seek(32'h0000_0010);
    repeat (2) p(1'b1, MODE_DATA, 16'h0000);
    settle();
    got(16'h3333);
    got(16'hffff);
  endtask
  task automatic t_lock_erase();
    for (int k = 0; k < 2; k++)
    begin
      p(1'b0, MODE_COMMAND, k ? CMD_ERASE_WRITE_LOCK : CMD_WRITE_LOCK);
      seek(32'h0000_0020);
      p(1'b0, MODE_DATA, 16'h4444);
      p(1'b0, MODE_COMMAND, CMD_ERASE_ALL);
      p(1'b0, MODE_DATA, ERASE_ALL_ARG);
      p(1'b0, MODE_COMMAND, CMD_READ);
      seek(32'h0000_0020);
      p(1'b1, MODE_DATA, 16'h0000);
      p(1'b0, MODE_COMMAND, CMD_UNLOCK_REGIONS);
      p(1'b0, MODE_COMMAND, CMD_ERASE_ALL);
      p(1'b0, MODE_DATA, ERASE_ALL_ARG);
      p(1'b0, MODE_COMMAND, CMD_READ);
      seek(32'h0000_0020);
      p(1'b1, MODE_DATA, 16'h0000);
      settle();
      got(16'h4444);
      got(16'hffff);
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // collector samples pre-edge values; also cuts a hang short
  always @(posedge clk_sys)
  begin
    if (rsp_valid === 1'b1) rdq.push_back(rsp_data);
    if (done === 1'b1) done_cnt++;
    if (req_ready === 1'b0 && req_valid === 1'b1) saw_full = 1'b1;
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_mode = '0;
    req_data = '0;
    slow = 1'b0;
    saw_full = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    @(posedge clk_sys) #1;
    t_fifo_full();
    t_page_write();
    t_erase_write();
    t_lock_erase();
    tally_and_finish();
  end
endmodule // tb_top
